// file: rtl/dsm_monitor_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: A 25 MHz system clock.
// Notes:   Definitions only; included by the monitor top.
`ifndef DSM_MONITOR_REGS_SVH
`define DSM_MONITOR_REGS_SVH

// ************************************************************
// Clock rate and times.
// ************************************************************
`define DSM_CLK_HZ        25000000
`define DSM_CLK_MHZ       (`DSM_CLK_HZ / 1000000)
`define DSM_DISC_TIME_S   3
`define DSM_SIM_TIME_S    10
`define DSM_DISC_CYC      (`DSM_DISC_TIME_S * `DSM_CLK_HZ)
`define DSM_SIM_CYC       (`DSM_SIM_TIME_S * `DSM_CLK_HZ)
`define DSM_TP_PERIOD_US  1000
`define DSM_TP_WIDTH_US   200
`define DSM_TP_PERIOD_CYC (`DSM_TP_PERIOD_US * `DSM_CLK_MHZ)
`define DSM_TP_WIDTH_CYC  (`DSM_TP_WIDTH_US * `DSM_CLK_MHZ)
`define DSM_TIMER_W       28
`define DSM_MAX_TAPS      32

// ************************************************************
// Register byte offsets.
// ************************************************************
`define DSM_OFS_CTRL      8'h00
`define DSM_OFS_STATUS    8'h04
`define DSM_OFS_ISTAT     8'h08
`define DSM_OFS_IMASK     8'h0c
`define DSM_OFS_NODE      8'h10

// ************************************************************
// Field positions and reset values.
// ************************************************************
`define DSM_CTRL_W        3
`define DSM_CTRL_RST      3'h4
`define DSM_INT_W         4
`define DSM_INT_SAFE      0
`define DSM_INT_OPER      1
`define DSM_INT_FAULT     2
`define DSM_INT_TPFAIL    3
`define DSM_NODE_W        5

`endif

// file: rtl/dsm_pkg.sv
// Purpose: Types shared by the input monitor files.
// Assumes: Nothing beyond the register header.
// Notes:   Enum codes are the language defaults, 0 to 3 in order.
package dsm_pkg;

  // Evaluation states of the tap.
  typedef enum logic [1:0] {
    ST_SAFE,
    ST_OPER,
    ST_FLT_LOW,
    ST_FLT_HIGH
  } dsm_state_t;

  // Input status indicator drive.
  typedef struct packed {
    logic red;
    logic green;
  } dsm_led_t;

  // Control register layout, msb first.
  typedef struct packed {
    logic tp_en;
    logic lock_cmd;
    logic contact;
  } dsm_ctrl_t;

endpackage : dsm_pkg

// file: rtl/dsm_span_timer.sv
// Purpose: Counts cycles of a condition and flags when a span is reached.
// Assumes: run_in is synchronous to clk_in.
// Notes:   The count saturates at the limit and clears when run drops.
`timescale 1ns/10ps

module dsm_span_timer #(
  parameter int W = 28
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         run_in,
  input  wire logic [W-1:0] limit_in,
  output logic              expired_out
);

  logic [W-1:0] cnt_r;  // Cycles for which run_in has held.

  // ************************************************************
  // Saturating span counter.
  // ************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || !run_in)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r != limit_in)
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // The span is over once the limit has been counted.
  assign expired_out = run_in && (cnt_r == limit_in);

endmodule : dsm_span_timer

// file: rtl/dsm_monitor.sv
// Purpose: Dual channel safety input evaluation inside a link tap.
// Assumes: Inputs synchronous to CLOCK_IN; sync active low reset.
// Notes:   Function
// Function
// - Switching outputs off gives safe, red.
// - Switching outputs on give green indicator.
// - Inputs disagreeing 3 s gives fault.
// - Switching fault clears after low then high.
// - Contact style sources 24V, senses return.
// - Contact channels are pulse tested.
// - Contacts open give safe, red.
// - Both contacts closed give operational, green.
// - Contacts must follow each other within 10 s.
// - Missed simultaneity window gives recoverable fault.
// - Contact fault clears after timely open, close.
// - Passive variant passes link signals unchanged.
// - Eight pin build selects lock output polarity.
// - Channel status is 1 valid, 0 safe.
// - Node address covers at most 32 taps.
`timescale 1ns/10ps
`include "dsm_monitor_regs.svh"

module dsm_monitor
  import dsm_pkg::*;
#(
  parameter int unsigned DISC_CYC    = `DSM_DISC_CYC,
  parameter int unsigned SIM_CYC     = `DSM_SIM_CYC,
  parameter int unsigned TP_PERIOD   = `DSM_TP_PERIOD_CYC,
  parameter int unsigned TP_WIDTH    = `DSM_TP_WIDTH_CYC,
  parameter bit          PASSIVE     = 1'b0,
  parameter bit          EIGHT_PIN   = 1'b1,
  parameter bit          LOCK_ENERGIZE = 1'b0
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic [31:0]      RDATA_OUT,
  input  wire logic [1:0]  SENSE_IN,
  output logic [1:0]       SOURCE_OUT,
  output dsm_led_t         LED_OUT,
  output logic             VALID_OUT,
  output logic             GUARD_LOCK_OUT,
  input  wire logic        UP_LINK_IN,
  output logic             UP_LINK_OUT,
  input  wire logic        DEV_LINK_IN,
  output logic             DEV_LINK_OUT,
  output logic             IRQ_OUT
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  localparam int TW = `DSM_TIMER_W;
  localparam int PW = $clog2(TP_PERIOD);

  dsm_ctrl_t                ctrl_r;      // Style, lock and test enable.
  logic [`DSM_INT_W-1:0]    istat_r;     // Sticky event bits.
  logic [`DSM_INT_W-1:0]    imask_r;     // Interrupt enables.
  logic [`DSM_NODE_W-1:0]   node_r;      // Tap position on the circuit.
  logic [`DSM_INT_W-1:0]    event_w;     // One cycle event pulses.
  dsm_state_t               state_r;     // Evaluation state.
  dsm_state_t               state_nxt;   // Next evaluation state.
  logic [1:0]               eval_w;      // Inputs seen by evaluation.
  logic [1:0]               held_r;      // Last input before a pulse.
  logic [1:0]               hold_w;      // Channel judged on held value.
  logic [PW-1:0]            tp_cnt_r;    // Position in test period.
  logic                     tp_ch_r;     // Channel under test.
  logic                     tp_run_w;    // Pulse testing is active.
  logic                     tp_on_w;     // A test pulse is applied.
  logic                     tp_chk_w;    // Last cycle of a pulse.
  logic                     tp_fail_w;   // Return stayed high in pulse.
  logic                     both_hi_w;   // Both channels energized.
  logic                     both_lo_w;   // Both channels off.
  logic                     expired_w;   // Disagreement span reached.
  logic                     late_r;      // A pair missed its window.
  logic [TW-1:0]            limit_w;     // Span for the input style.
  logic [1:0]               source_r;    // Contact supply drive.
  dsm_led_t                 led_r;       // Indicator drive.
  logic                     valid_r;     // Channel status bit.
  logic                     lock_r;      // Guard locking drive.
  logic                     up_r;        // Upstream link out.
  logic                     dev_r;       // Device link out.
  logic [31:0]              rdata_r;     // Read data register.

  // ************************************************************
  // Register bus slave.
  // ************************************************************

  // Writes to control, mask and node address.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      ctrl_r  <= `DSM_CTRL_RST;
      imask_r <= '0;
      node_r  <= '0;
    end
    else if (WR_IN)
    begin
      case (ADDR_IN)
        `DSM_OFS_CTRL:  ctrl_r  <= WDATA_IN[`DSM_CTRL_W-1:0];
        `DSM_OFS_IMASK: imask_r <= WDATA_IN[`DSM_INT_W-1:0];
        // Five bits address one of 32 taps.
        `DSM_OFS_NODE:  node_r  <= WDATA_IN[`DSM_NODE_W-1:0];
        default:        ;
      endcase
    end
  end

  // Sticky status; an event in the clearing cycle is kept.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      istat_r <= '0;
    end
    else if (WR_IN && (ADDR_IN == `DSM_OFS_ISTAT))
    begin
      istat_r <= (istat_r & ~WDATA_IN[`DSM_INT_W-1:0]) | event_w;
    end
    else
    begin
      istat_r <= istat_r | event_w;
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN || !RD_IN)
    begin
      rdata_r <= '0;
    end
    else
    begin
      case (ADDR_IN)
        `DSM_OFS_CTRL:   rdata_r <= {29'h0, ctrl_r};
        `DSM_OFS_STATUS: rdata_r <= {24'h0, led_r, eval_w, valid_r,
                                     late_r, state_r};
        `DSM_OFS_ISTAT:  rdata_r <= {28'h0, istat_r};
        `DSM_OFS_IMASK:  rdata_r <= {28'h0, imask_r};
        `DSM_OFS_NODE:   rdata_r <= {27'h0, node_r};
        default:         rdata_r <= '0;
      endcase
    end
  end

  assign RDATA_OUT = rdata_r;
  assign IRQ_OUT   = |(istat_r & imask_r);

  // ************************************************************
  // Contact supply and pulse test.
  // ************************************************************

  // Switching outputs get no pulses; that device tests itself.
  assign tp_run_w = ctrl_r.contact && ctrl_r.tp_en && !PASSIVE;
  assign tp_on_w  = tp_run_w && (tp_cnt_r >= PW'(TP_PERIOD - TP_WIDTH));
  assign tp_chk_w = tp_run_w && (tp_cnt_r == PW'(TP_PERIOD - 1));
  // The return must fall while its supply is pulsed off.
  assign tp_fail_w = tp_chk_w && SENSE_IN[tp_ch_r];

  // Test period counter; channels are pulsed in turn.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN || !tp_run_w)
    begin
      tp_cnt_r <= '0;
      tp_ch_r  <= 1'b0;
    end
    else if (tp_chk_w)
    begin
      tp_cnt_r <= '0;
      tp_ch_r  <= ~tp_ch_r;
    end
    else
    begin
      tp_cnt_r <= tp_cnt_r + 1'b1;
    end
  end

  // Supply both contacts, dropping one during its pulse.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN || !ctrl_r.contact || PASSIVE)
    begin
      source_r <= 2'h0;
    end
    else
    begin
      source_r <= 2'h3;
      if (tp_on_w)
      begin
        source_r[tp_ch_r] <= 1'b0;
      end
    end
  end

  assign SOURCE_OUT = source_r;

  // Per channel: a pulsed channel is judged on its held value.
  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    // The supply lags the pulse by one cycle, so the hold covers it too.
    assign hold_w[i] = (tp_on_w && (tp_ch_r == i)) ||
                       (ctrl_r.contact && !PASSIVE && !source_r[i]);
    assign eval_w[i] = hold_w[i] ? held_r[i] : SENSE_IN[i];
    always_ff @(posedge CLOCK_IN)
    begin
      if (!RESETN_IN)
      begin
        held_r[i] <= 1'b0;
      end
      else if (!hold_w[i])
      begin
        held_r[i] <= SENSE_IN[i];
      end
    end
  end

  // ************************************************************
  // Discrepancy and simultaneity timing.
  // ************************************************************
  assign both_hi_w = &eval_w;
  assign both_lo_w = ~|eval_w;
  // Three seconds for switching outputs, ten for contacts.
  assign limit_w = ctrl_r.contact ? TW'(SIM_CYC) : TW'(DISC_CYC);

  dsm_span_timer #(
    .W (TW)
  ) u_span (
    .clk_in      (CLOCK_IN),
    .rstn_in     (RESETN_IN),
    .run_in      (^eval_w),
    .limit_in    (limit_w),
    .expired_out (expired_w)
  );

  // A late pair is remembered until both channels are on again.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN || both_hi_w)
    begin
      late_r <= 1'b0;
    end
    else if (expired_w)
    begin
      late_r <= 1'b1;
    end
  end

  // ************************************************************
  // Evaluation state machine.
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_SAFE:
      begin
        if (expired_w || tp_fail_w)
        begin
          state_nxt = ST_FLT_LOW;
        end
        else if (both_hi_w)
        begin
          state_nxt = ST_OPER;
        end
      end
      ST_OPER:
      begin
        if (tp_fail_w)
        begin
          state_nxt = ST_FLT_LOW;
        end
        else if (!both_hi_w)
        begin
          state_nxt = ST_SAFE;
        end
      end
      ST_FLT_LOW:
      begin
        // A late open pair does not count toward recovery.
        if (both_lo_w && !(ctrl_r.contact && late_r))
        begin
          state_nxt = ST_FLT_HIGH;
        end
      end
      ST_FLT_HIGH:
      begin
        if (ctrl_r.contact && (expired_w || tp_fail_w))
        begin
          state_nxt = ST_FLT_LOW;
        end
        else if (both_hi_w)
        begin
          state_nxt = ST_OPER;
        end
      end
      default:
      begin
        state_nxt = ST_SAFE;
      end
    endcase
    // A passive tap evaluates nothing.
    if (PASSIVE)
    begin
      state_nxt = ST_SAFE;
    end
  end

  // State register.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      state_r <= ST_SAFE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Indicator and status follow the next state into step.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN)
    begin
      led_r   <= '{red: 1'b1, green: 1'b0};
      valid_r <= 1'b0;
    end
    else
    begin
      led_r.green <= (state_nxt == ST_OPER);
      led_r.red   <= (state_nxt != ST_OPER);
      valid_r     <= (state_nxt == ST_OPER);
    end
  end

  assign LED_OUT   = led_r;
  assign VALID_OUT = valid_r;

  // Events for the sticky status register.
  assign event_w[`DSM_INT_SAFE]   = (state_nxt == ST_SAFE) &&
                                    (state_r != ST_SAFE);
  assign event_w[`DSM_INT_OPER]   = (state_nxt == ST_OPER) &&
                                    (state_r != ST_OPER);
  assign event_w[`DSM_INT_FAULT]  = (state_nxt == ST_FLT_LOW) &&
                                    ((state_r == ST_SAFE) ||
                                     (state_r == ST_OPER));
  assign event_w[`DSM_INT_TPFAIL] = tp_fail_w;

  // ************************************************************
  // Guard locking output and link pass-through.
  // ************************************************************

  // The build picks whether energizing locks or unlocks.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN || !EIGHT_PIN)
    begin
      lock_r <= 1'b0;
    end
    else
    begin
      lock_r <= LOCK_ENERGIZE ? ctrl_r.lock_cmd
                              : !ctrl_r.lock_cmd;
    end
  end

  // Passive taps forward the link both ways, one cycle late.
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RESETN_IN || !PASSIVE)
    begin
      up_r  <= 1'b0;
      dev_r <= 1'b0;
    end
    else
    begin
      dev_r <= UP_LINK_IN;
      up_r  <= DEV_LINK_IN;
    end
  end

  assign GUARD_LOCK_OUT = lock_r;
  assign UP_LINK_OUT    = up_r;
  assign DEV_LINK_OUT   = dev_r;

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence fault_low_s;
    state_r == ST_FLT_LOW && both_lo_w && !late_r;
  endsequence

  sequence fault_high_s;
    state_r == ST_FLT_HIGH && both_hi_w && !expired_w && !tp_fail_w;
  endsequence

  safe_red_a: assert property (
    (state_r != ST_OPER) |-> (led_r.red && !led_r.green))
    else $error("Indicator not red outside operation");

  oper_green_a: assert property (
    (state_r == ST_OPER) |-> (led_r.green && !led_r.red))
    else $error("Indicator not green in operation");

  disc_fault_a: assert property (
    (!ctrl_r.contact && state_r == ST_SAFE && ^eval_w &&
     limit_w == TW'(DISC_CYC)) [*2] ##0 expired_w |=>
    state_r == ST_FLT_LOW)
    else $error("Discrepancy did not raise the fault");

  recover_a: assert property (
    fault_low_s ##1 fault_high_s |=> state_r == ST_OPER)
    else $error("Fault did not clear after low then high");

  supply_a: assert property (
    (ctrl_r.contact && !PASSIVE && !$past(tp_on_w) &&
     $past(ctrl_r.contact)) |-> source_r == 2'h3)
    else $error("Contact supply not applied");

  pulse_fail_a: assert property (
    tp_fail_w |=> istat_r[`DSM_INT_TPFAIL] && state_r == ST_FLT_LOW)
    else $error("Pulse test fault not caught");

  close_oper_a: assert property (
    (state_r == ST_SAFE && both_hi_w && !tp_fail_w && !PASSIVE) |=>
    (state_r == ST_OPER) && VALID_OUT)
    else $error("Closed contacts did not give operation");

  sim_fault_a: assert property (
    (ctrl_r.contact && state_r == ST_SAFE && expired_w) |=>
    state_r == ST_FLT_LOW && late_r)
    else $error("Missed window did not raise the fault");

  late_block_a: assert property (
    (ctrl_r.contact && state_r == ST_FLT_LOW && late_r) |=>
    state_r == ST_FLT_LOW)
    else $error("Late pair cleared the fault");

  valid_a: assert property (
    VALID_OUT == (state_r == ST_OPER))
    else $error("Channel status does not match state");

  fault_invalid_a: assert property (
    (state_r == ST_FLT_LOW || state_r == ST_FLT_HIGH) |-> !VALID_OUT)
    else $error("Fault reported as valid");

  pass_a: assert property (
    PASSIVE |=> DEV_LINK_OUT == $past(UP_LINK_IN) &&
                UP_LINK_OUT == $past(DEV_LINK_IN))
    else $error("Passive link not forwarded");

  lock_pol_a: assert property (
    EIGHT_PIN && $stable(ctrl_r) |=>
    GUARD_LOCK_OUT == (LOCK_ENERGIZE == $past(ctrl_r.lock_cmd)))
    else $error("Guard lock polarity wrong");

endmodule : dsm_monitor

// file: test/dsm_dev_model.sv
// Purpose: Behavioural safety device wired to the tap's input pins.
// Assumes: Contacts return the tap's supply; an open line reads low.
// Notes:   A short welds a channel to the supply when the bench asks.
`timescale 1ns/10ps

module dsm_dev_model (
  input  wire logic [1:0] source_in,
  input  wire logic       contact_in,
  input  wire logic [1:0] close_in,
  input  wire logic [1:0] short_in,
  output logic      [1:0] sense_out
);
  // **********************************************************
  // Channel returns.
  // **********************************************************
  // Contacts pass the supply back only while closed and sourced.
  always_comb
  begin
    if (contact_in)
      sense_out = (source_in & close_in) | short_in;
    else
      sense_out = close_in;
  end
endmodule : dsm_dev_model

// file: test/tb.sv
// Purpose: Self-checking bench for the dual channel input monitor.
// Assumes: Shortened spans on the active instance so that its timeouts are reached quickly.
// Notes:   A passive instance beside the active one checks the link.
`timescale 1ns/10ps

module tb;
  import dsm_pkg::*;
  localparam int DC  = 20;  // Shortened discrepancy span.
  localparam int SC  = 40;  // Shortened simultaneity span.
  localparam int TPP = 16;  // Shortened pulse test period.
  localparam int TPW = 4;   // Shortened pulse test width.
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  sense, source;
  logic [1:0]  close_c = 2'h0;
  logic [1:0]  short_c = 2'h0;
  logic        contact = 1'b0;
  dsm_led_t    led;
  logic        valid, lock, irq, upo, devo;
  logic        up = 1'b0;
  logic        dev = 1'b0;
  logic        p_upo, p_devo, p_valid;
  int          err_total = 0;
  int          check_count = 0;
  logic [1:0]  link_q[$];   // Link inputs awaiting their copies.
  logic [31:0] d;
  int          lo0, lo1;

  always #20 clk = ~clk;

  dsm_monitor #(.DISC_CYC(DC), .SIM_CYC(SC), .TP_PERIOD(TPP),
    .TP_WIDTH(TPW)) u_dut (.CLOCK_IN(clk), .RESETN_IN(rstn),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .SENSE_IN(sense), .SOURCE_OUT(source),
    .LED_OUT(led), .VALID_OUT(valid), .GUARD_LOCK_OUT(lock),
    .UP_LINK_IN(up), .UP_LINK_OUT(upo), .DEV_LINK_IN(dev),
    .DEV_LINK_OUT(devo), .IRQ_OUT(irq));

  dsm_monitor #(.PASSIVE(1'b1)) u_pas (.CLOCK_IN(clk),
    .RESETN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(), .SENSE_IN(sense), .SOURCE_OUT(),
    .LED_OUT(), .VALID_OUT(p_valid), .GUARD_LOCK_OUT(),
    .UP_LINK_IN(up), .UP_LINK_OUT(p_upo), .DEV_LINK_IN(dev),
    .DEV_LINK_OUT(p_devo), .IRQ_OUT());

  dsm_dev_model u_devm (.source_in(source), .contact_in(contact),
    .close_in(close_c), .short_in(short_c), .sense_out(sense));

  // **********************************************************
  // Compare and report tasks.
  // **********************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Compares one flag.
  task automatic chk_bit(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk_bit

  // Compares one word.
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e,
                          input string m);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_word

  // **********************************************************
  // Bus and stimulus tasks.
  // **********************************************************
  // One-cycle write strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // One-cycle read strobe; data is taken in the following cycle.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg

  // Model of the outputs: only the operational state is valid, green.
  task automatic chk_st(input int s);
    logic [31:0] v;
    rd_reg(8'h04, v);
    chk_word({30'h0, v[1:0]}, s, "state");
    chk_bit(valid, s == 1, "valid");
    chk_word({30'h0, led}, (s == 1) ? 32'h1 : 32'h2, "led");
  endtask : chk_st

  // Sets the contacts and lets the state settle past a test pulse.
  task automatic drive(input logic [1:0] v);
    @(posedge clk);
    close_c <= v;
    repeat (TPW + 4) @(posedge clk);
    @(negedge clk);
  endtask : drive

  // Arms one event, applies stimulus and times the interrupt.
  task automatic wait_irq(input logic [3:0] msk, input logic [1:0] cl,
                          input logic [1:0] sh, input int lo,
                          input int hi);
    int n;
    wr_reg(8'h08, 32'hf);
    wr_reg(8'h0c, {28'h0, msk});
    close_c <= cl;
    short_c <= sh;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (irq !== 1'b1 && n < hi);
    chk_bit(irq === 1'b1 && n >= lo, 1'b1, "event timing");
    if (irq !== 1'b1)
      print_verdict();
    @(negedge clk);
  endtask : wait_irq

  // **********************************************************
  // Link pass model: copies appear one edge later, crossed over.
  // **********************************************************
  always @(posedge clk)
  begin
    if (rstn)
      link_q.push_back({dev, up});
    up <= 1'($urandom);
    dev <= 1'($urandom);
  end

  always @(negedge clk)
  begin
    if (link_q.size() > 0)
    begin
      chk_word({30'h0, p_upo, p_devo}, {30'h0, link_q.pop_front()},
               "passive link");
      chk_word({29'h0, upo, devo, p_valid}, 32'h0, "idle link");
    end
  end

  // **********************************************************
  // Main sequence.
  // **********************************************************
  initial
  begin
    void'($urandom(32'h2713913f));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk_st(0);
    chk_word({30'h0, source}, 32'h0, "no supply");
    rd_reg(8'h00, d);
    chk_word(d, 32'h4, "ctrl reset");
    rd_reg(8'h20, d);
    chk_word(d, 32'h0, "unmapped");
    wr_reg(8'h10, 32'hffffffff);
    rd_reg(8'h10, d);
    chk_word(d, 32'h1f, "node");
    // Switching outputs: energize, mask, clear.
    wait_irq(4'h2, 2'b11, 2'b00, 1, 6);
    chk_st(1);
    wr_reg(8'h08, 32'h2);
    drive(2'b00);
    chk_bit(irq, 1'b0, "masked event");
    chk_st(0);
    // Disagreement shorter than the span is forgiven.
    drive(2'b01);
    repeat (DC / 4 + $urandom_range(0, 3)) @(posedge clk);
    drive(2'b11);
    chk_st(1);
    wait_irq(4'h4, 2'b10, 2'b00, DC, DC + 4);
    chk_st(2);
    drive(2'b11);
    chk_st(2);
    drive(2'b00);
    chk_st(3);
    drive(2'b11);
    chk_st(1);
    // Lock polarity follows the command inverted.
    wr_reg(8'h00, 32'h6);
    repeat (2) @(negedge clk);
    chk_bit(lock, 1'b0, "lock set");
    wr_reg(8'h00, 32'h4);
    repeat (2) @(negedge clk);
    chk_bit(lock, 1'b1, "lock clear");
    // Contact style: supply with pulses, one channel per period in turn.
    drive(2'b00);
    wr_reg(8'h00, 32'h5);
    contact <= 1'b1;
    repeat (4) @(posedge clk);
    lo0 = 0;
    lo1 = 0;
    repeat (2 * TPP)
    begin
      @(negedge clk);
      lo0 += (source[0] === 1'b0);
      lo1 += (source[1] === 1'b0);
    end
    chk_word(lo0, TPW, "pulse ch0");
    chk_word(lo1, TPW, "pulse ch1");
    drive(2'b11);
    repeat (2 * TPP) @(posedge clk);
    chk_st(1);
    drive(2'b10);
    chk_st(0);
    drive(2'b00);
    drive(2'b01);
    drive(2'b11);
    chk_st(1);
    // Late follower faults; the late pair blocks recovery.
    wait_irq(4'h4, 2'b10, 2'b00, SC, SC + TPW + 4);
    chk_st(2);
    drive(2'b00);
    chk_st(2);
    drive(2'b11);
    chk_st(2);
    drive(2'b00);
    chk_st(3);
    drive(2'b11);
    chk_st(1);
    // A welded channel fails its pulse test.
    wait_irq(4'h8, 2'b11, 2'b01, 1, 2 * TPP + 6);
    chk_st(2);
    @(posedge clk);
    short_c <= 2'b00;
    drive(2'b00);
    drive(2'b11);
    chk_st(1);
    // With pulse testing off the supply stays on both channels.
    wr_reg(8'h00, 32'h1);
    repeat (2) @(negedge clk);
    lo0 = 0;
    repeat (2 * TPP)
    begin
      @(negedge clk);
      lo0 += (source !== 2'h3);
    end
    chk_word(lo0, 32'h0, "no pulses");
    print_verdict();
  end
endmodule : tb
